// >>> timer2_consts.svh
/*
 * Register map, field positions, reset values and timing counts
 * for the 8-bit period timer. Included by the design modules and the
 * bench; definitions only.
 */
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// register offsets on the byte-wide register port
`define ADDR_PERIPHERAL_FLAG 8'h0c
`define ADDR_TIMER2_COUNT 8'h11
`define ADDR_TIMER2_CONTROL 8'h12
`define ADDR_PERIOD_REG 8'h92

// reset values
`define RESET_TIMER2_COUNT 8'h00
`define RESET_TIMER2_CONTROL 7'h00
`define RESET_PERIOD_REG 8'hff

// field positions
`define PRESCALE_LSB 0
`define PRESCALE_MSB 1
`define COUNT_ENABLE_BIT 2
`define POSTSCALE_LSB 3
`define POSTSCALE_MSB 6
`define MATCH_FLAG_BIT 1

// oscillator clocks per instruction cycle
`define OSC_CLK_PER_INSTR 4
`define OSC_FREQ_HZ 50000000

// prescaler terminal counts in instruction cycles
`define PRESCALE_TERM_DIV1 4'h0
`define PRESCALE_TERM_DIV4 4'h3
`define PRESCALE_TERM_DIV16 4'hf

`endif

// >>> timer2_pkg.sv
/*
 * Types shared by the period timer and its postscaler.
 * Assumes timer2_consts.svh is on the include path.
 */
package timer2_pkg;

    // software-visible control fields, bit 7 not held
    typedef struct packed {
        logic [3:0] postscale_select;
        logic count_enable;
        logic [1:0] prescale_select;
    } control_type;

    // one register-port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // time base handed to the pwm unit
    typedef struct packed {
        logic [7:0] count;
        logic match;
    } time_base_type;

    // whole state of the timer
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] pre;
        logic [7:0] count;
        control_type control;
        logic [7:0] period;
        logic flag;
        logic match;
        logic post_clear;
        logic [7:0] rd_data;
    } timer_state_type;

    // whole state of the postscaler
    typedef struct packed {
        logic [3:0] cnt;
        logic done;
    } post_state_type;

endpackage : timer2_pkg

// >>> postscaler.sv
/*
 * Match postscaler: divides period-match pulses by select+1.
 * Assumes tick and clear are one-cycle pulses on clk.
 */
`include "timer2_consts.svh"

module postscaler #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic clear,
    input wire logic [WIDTH-1:0] select,
    output logic done
);
    import timer2_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic done;
    } scale_state_type;

    scale_state_type q;
    scale_state_type d;

    // clear beats a match in the same cycle
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (clear) begin
            d.cnt = '0;
        end else if (tick) begin
            if (q.cnt == select) begin
                d.cnt = '0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;

endmodule : postscaler

// >>> period_timer.sv
/*
 * 8-bit period timer with prescaler, period register and match
 * postscaler; exports its count and match pulse as a pwm time
 * base and the match pulse as a serial shift-clock source.
 * Assumes clk is the oscillator, reset_n merges power-on,
 * external pin and watchdog resets, and the register port is
 * driven from logic on clk.
 */
// Chosen here: the plain strobed port.
// Functional notes
// - count advances on instruction clock (osc/4) after divide-by 1, 4 or 16 prescaler
// - prescale ratio set by two lowest bits of timer2_control
// - count runs from 00h to period_reg, then returns to 00h next increment
// - period_reg is read/write and loads all ones on every reset
// - timer2_count is read/write and clears to zero on every reset
// - each match steps a 4-bit postscaler; its completion sets period_match_flag bit 1
// - clearing count_enable (bit 2) stops counting; setting it resumes
// - prescaler and postscaler clear on count write, control write and reset
// - control write keeps the count; only reset, count write or an increment alter it
// - pre-postscaler match pulse goes to the serial port for its shift clock
// - count and match pulse serve as the pwm time base
`include "timer2_consts.svh"

module period_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire timer2_pkg::bus_req_type bus_req,
    output logic [7:0] rd_data,
    output logic period_match_flag,
    output logic shift_clock_match,
    output timer2_pkg::time_base_type pwm_time_base
);
    import timer2_pkg::*;

    timer_state_type q;
    timer_state_type d;
    logic instr_tick;
    logic [3:0] pre_term;
    logic pre_wrap;
    logic count_tick;
    logic post_done;
    logic wr_count;
    logic wr_control;
    logic wr_period;
    logic wr_flag;
    logic rd_hit;

    // register-port decode
    assign wr_count = bus_req.wr && (bus_req.addr == `ADDR_TIMER2_COUNT);
    assign wr_control = bus_req.wr && (bus_req.addr == `ADDR_TIMER2_CONTROL);
    assign wr_period = bus_req.wr && (bus_req.addr == `ADDR_PERIOD_REG);
    assign wr_flag = bus_req.wr && (bus_req.addr == `ADDR_PERIPHERAL_FLAG);
    assign rd_hit = bus_req.rd;

    // instruction cycle is the last oscillator phase of four
    assign instr_tick = (q.phase == 2'(`OSC_CLK_PER_INSTR - 1));

    // prescaler terminal count from the select field
    always_comb begin
        unique case (q.control.prescale_select)
            2'b00: pre_term = `PRESCALE_TERM_DIV1;
            2'b01: pre_term = `PRESCALE_TERM_DIV4;
            2'b10: pre_term = `PRESCALE_TERM_DIV16;
            2'b11: pre_term = `PRESCALE_TERM_DIV16;
        endcase
    end

    // one count increment per prescaler wrap while enabled
    assign pre_wrap = (q.pre >= pre_term);
    assign count_tick = instr_tick && q.control.count_enable && pre_wrap;

    // match postscaler, cleared on count or control write
    postscaler #(
        .WIDTH(4)
    ) u_postscaler (
        .clk(clk),
        .reset_n(reset_n),
        .tick(q.match),
        .clear(q.post_clear),
        .select(q.control.postscale_select),
        .done(post_done)
    );

    // next-state logic for the whole timer
    always_comb begin
        d = q;
        d.match = 1'b0;
        d.post_clear = 1'b0;
        d.rd_data = 8'h00;
        // free-running oscillator phase counter
        d.phase = q.phase + 2'h1;
        // prescaler advances on instruction cycles while enabled
        if (instr_tick && q.control.count_enable) begin
            if (pre_wrap) begin
                d.pre = 4'h0;
            end else begin
                d.pre = q.pre + 4'h1;
            end
        end
        // count step with wrap at the period value
        if (count_tick) begin
            if (q.count == q.period) begin
                d.count = 8'h00;
                d.match = 1'b1;
            end else begin
                d.count = q.count + 8'h01;
            end
        end
        // software write to the count wins over an increment
        if (wr_count) begin
            d.count = bus_req.wdata;
            d.match = 1'b0;
            d.pre = 4'h0;
            d.post_clear = 1'b1;
        end
        // control write clears the scalers and keeps the count
        if (wr_control) begin
            d.control = control_type'(bus_req.wdata[`POSTSCALE_MSB:`PRESCALE_LSB]);
            d.pre = 4'h0;
            d.post_clear = 1'b1;
        end
        // period register write
        if (wr_period) begin
            d.period = bus_req.wdata;
        end
        // software may write the flag; a postscaler completion wins
        if (wr_flag) begin
            d.flag = bus_req.wdata[`MATCH_FLAG_BIT];
        end
        if (post_done) begin
            d.flag = 1'b1;
        end
        // read data, valid in the cycle after the strobe
        if (rd_hit) begin
            unique case (bus_req.addr)
                `ADDR_TIMER2_COUNT: begin
                    d.rd_data = q.count;
                end
                `ADDR_TIMER2_CONTROL: begin
                    d.rd_data = {1'b0, q.control};
                end
                `ADDR_PERIOD_REG: begin
                    d.rd_data = q.period;
                end
                `ADDR_PERIPHERAL_FLAG: begin
                    d.rd_data = 8'(q.flag) << `MATCH_FLAG_BIT;
                end
                default: begin
                    d.rd_data = 8'h00;
                end
            endcase
        end
    end

    // state register; reset loads documented values
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q.phase <= 2'h0;
            q.pre <= 4'h0;
            q.count <= `RESET_TIMER2_COUNT;
            q.control <= `RESET_TIMER2_CONTROL;
            q.period <= `RESET_PERIOD_REG;
            q.flag <= 1'b0;
            q.match <= 1'b0;
            q.post_clear <= 1'b0;
            q.rd_data <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // outputs, all from flip-flops
    assign rd_data = q.rd_data;
    assign period_match_flag = q.flag;
    assign shift_clock_match = q.match;
    assign pwm_time_base = '{count: q.count, match: q.match};

    // assertions on the timer state

    // increment taken at the period value wraps and pulses match
    property count_wrap_p;
        @(posedge clk) disable iff (!reset_n)
        (count_tick && (q.count == q.period) && !wr_count) |=> (q.count == 8'h00) && q.match;
    endproperty
    count_wrap_a: assert property (count_wrap_p)
        else $error("count did not wrap at period");

    // increment below the period steps by exactly one
    property count_step_p;
        @(posedge clk) disable iff (!reset_n)
        (count_tick && (q.count != q.period) && !wr_count) |=> (q.count == $past(q.count) + 8'h01) && !q.match;
    endproperty
    count_step_a: assert property (count_step_p)
        else $error("count did not step by one");

    // control write never changes the count
    property control_keeps_p;
        @(posedge clk) disable iff (!reset_n)
        (wr_control && !wr_count && !count_tick) |=> $stable(q.count) && (q.pre == 4'h0);
    endproperty
    control_keeps_a: assert property (control_keeps_p)
        else $error("control write altered count");

    // count write loads the value and clears the prescaler
    property count_write_p;
        @(posedge clk) disable iff (!reset_n)
        wr_count |=> (q.count == $past(bus_req.wdata)) && (q.pre == 4'h0) && q.post_clear;
    endproperty
    count_write_a: assert property (count_write_p)
        else $error("count write not taken");

    // stopped timer holds its count
    property stopped_hold_p;
        @(posedge clk) disable iff (!reset_n)
        (!q.control.count_enable && !wr_count) |=> $stable(q.count);
    endproperty
    stopped_hold_a: assert property (stopped_hold_p)
        else $error("count moved while disabled");

    // postscaler completion raises the flag next cycle
    property flag_set_p;
        @(posedge clk) disable iff (!reset_n)
        post_done |=> q.flag;
    endproperty
    flag_set_a: assert property (flag_set_p)
        else $error("flag not set on postscaler completion");

    // divide-by-1: ticks exactly four oscillator clocks apart
    sequence div1_tick_s;
        count_tick && (q.control.prescale_select == 2'b00);
    endsequence
    sequence quiet_bus_s;
        (!bus_req.wr)[*4];
    endsequence
    property div1_spacing_p;
        @(posedge clk) disable iff (!reset_n)
        div1_tick_s ##0 (!bus_req.wr) ##1 quiet_bus_s |-> count_tick;
    endproperty
    div1_spacing_a: assert property (div1_spacing_p)
        else $error("divide-by-1 spacing wrong");

    // no early tick after a divide-by-1 tick
    property div1_gap_p;
        @(posedge clk) disable iff (!reset_n)
        div1_tick_s |=> (!count_tick)[*3];
    endproperty
    div1_gap_a: assert property (div1_gap_p)
        else $error("tick came early");

    // period write is stored
    property period_write_p;
        @(posedge clk) disable iff (!reset_n)
        wr_period |=> (q.period == $past(bus_req.wdata));
    endproperty
    period_write_a: assert property (period_write_p)
        else $error("period write lost");

    // count read returns the count of the strobe cycle
    property count_read_p;
        @(posedge clk) disable iff (!reset_n)
        (bus_req.rd && (bus_req.addr == `ADDR_TIMER2_COUNT)) |=> (rd_data == $past(q.count));
    endproperty
    count_read_a: assert property (count_read_p)
        else $error("count read wrong");

    // a match pulse always shows a zero count to the pwm unit
    property match_zero_p;
        @(posedge clk) disable iff (!reset_n)
        q.match |-> (pwm_time_base.count == 8'h00) && pwm_time_base.match && shift_clock_match;
    endproperty
    match_zero_a: assert property (match_zero_p)
        else $error("match pulse without zero count");

    // oscillator phase advances by one on every clock
    property phase_run_p;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> (q.phase == 2'($past(q.phase) + 2'h1));
    endproperty
    phase_run_a: assert property (phase_run_p)
        else $error("instruction phase skipped");

    // divide-by-4 increments only at prescaler value 3
    property div4_term_p;
        @(posedge clk) disable iff (!reset_n)
        (count_tick && (q.control.prescale_select == 2'b01)) |-> (q.pre == 4'h3);
    endproperty
    div4_term_a: assert property (div4_term_p)
        else $error("divide-by-4 terminal count wrong");

    // both divide-by-16 codes increment only at prescaler value 15
    property div16_term_p;
        @(posedge clk) disable iff (!reset_n)
        (count_tick && q.control.prescale_select[1]) |-> (q.pre == 4'hf);
    endproperty
    div16_term_a: assert property (div16_term_p)
        else $error("divide-by-16 terminal count wrong");

    // stopped timer freezes its prescaler unless software clears it
    property stopped_pre_p;
        @(posedge clk) disable iff (!reset_n)
        (!q.control.count_enable && !wr_count && !wr_control) |=> $stable(q.pre);
    endproperty
    stopped_pre_a: assert property (stopped_pre_p)
        else $error("prescaler moved while disabled");

    // control write stores the fields and clears the postscaler
    property control_write_p;
        @(posedge clk) disable iff (!reset_n)
        wr_control |=> (q.control == $past(bus_req.wdata[`POSTSCALE_MSB:`PRESCALE_LSB])) && q.post_clear;
    endproperty
    control_write_a: assert property (control_write_p)
        else $error("control write not taken");

    // software clear of the flag holds when no completion competes
    property flag_clear_p;
        @(posedge clk) disable iff (!reset_n)
        (wr_flag && !bus_req.wdata[`MATCH_FLAG_BIT] && !post_done) |=> !q.flag;
    endproperty
    flag_clear_a: assert property (flag_clear_p)
        else $error("flag clear lost");

    // flag stays set until software writes it
    property flag_sticky_p;
        @(posedge clk) disable iff (!reset_n)
        (q.flag && !wr_flag) |=> q.flag;
    endproperty
    flag_sticky_a: assert property (flag_sticky_p)
        else $error("flag dropped by itself");

    // read data is zero outside the cycle after a read strobe
    property read_idle_p;
        @(posedge clk) disable iff (!reset_n)
        !bus_req.rd |=> (rd_data == 8'h00);
    endproperty
    read_idle_a: assert property (read_idle_p)
        else $error("read data not idle");

    // control read shows bit 7 as zero
    property control_read_p;
        @(posedge clk) disable iff (!reset_n)
        (bus_req.rd && (bus_req.addr == `ADDR_TIMER2_CONTROL)) |=> (rd_data == {1'b0, $past(q.control)});
    endproperty
    control_read_a: assert property (control_read_p)
        else $error("control read wrong");

    // flag register read places the flag in bit 1 only
    property flag_read_p;
        @(posedge clk) disable iff (!reset_n)
        (bus_req.rd && (bus_req.addr == `ADDR_PERIPHERAL_FLAG)) |=> (rd_data == {6'h00, $past(q.flag), 1'b0});
    endproperty
    flag_read_a: assert property (flag_read_p)
        else $error("flag read wrong");

endmodule : period_timer

// >>> period_timer_tb.sv
/*
 * Self-checking bench for the 8-bit period timer: register access,
 * prescale and postscale ratios, enable, scaler clearing and reset.
 * Assumes the package and timer2_consts.svh are compiled first.
 */
`include "timer2_consts.svh"

module period_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import timer2_pkg::*;

    logic clk;
    logic reset_n;
    bus_req_type req;
    logic [7:0] rd_data;
    logic flag;
    logic sclk_match;
    time_base_type tbase;
    int mismatches;
    int checks;
    int n;
    int m;
    logic [7:0] v;
    logic [7:0] v2;

    period_timer u_period_timer (
        .clk(clk),
        .reset_n(reset_n),
        .bus_req(req),
        .rd_data(rd_data),
        .period_match_flag(flag),
        .shift_clock_match(sclk_match),
        .pwm_time_base(tbase)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic timeout(input string name);
        mismatches++;
        $display("[ERR] %s expected event seen timeout", name);
        final_report();
    endtask : timeout

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask : rdchk

    // cycles up to and including the next match pulse
    task automatic wait_match(output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (tbase.match !== 1'b1 && cyc < 1000);
        if (cyc >= 1000) timeout("match");
    endtask : wait_match

    // spacing of two matches, count at zero with the first pulse
    task automatic meas(input int exp);
        int c;
        wait_match(c);
        chk("count at match", 8'h00, tbase.count);
        chk("shift clock match", 8'h01, {7'h00, sclk_match});
        wait_match(c);
        chk("match spacing", 8'(exp), 8'(c));
    endtask : meas

    // write, then no increment before 16 instruction ticks elapse
    task automatic clr_test(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp0);
        logic [7:0] d0;
        repeat (30) @(posedge clk);
        wr(a, d);
        rd(`ADDR_TIMER2_COUNT, d0);
        chk("count after write", exp0, d0);
        repeat (48) @(posedge clk);
        rdchk(`ADDR_TIMER2_COUNT, exp0, "count prescaler cleared");
        repeat (16) @(posedge clk);
        rdchk(`ADDR_TIMER2_COUNT, exp0 + 8'h01, "count next tick");
    endtask : clr_test

    initial begin
        reset_n = 1'b0;
        req = '0;
        mismatches = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        // reset values and plain access
        rdchk(`ADDR_TIMER2_COUNT, 8'h00, "count reset");
        rdchk(`ADDR_TIMER2_CONTROL, 8'h00, "control reset");
        rdchk(`ADDR_PERIOD_REG, 8'hff, "period reset");
        rdchk(`ADDR_PERIPHERAL_FLAG, 8'h00, "flag reg reset");
        wr(8'h40, 8'h5a);
        rdchk(8'h40, 8'h00, "unmapped read");
        rdchk(`ADDR_PERIOD_REG, 8'hff, "period after unmapped write");
        wr(`ADDR_PERIOD_REG, 8'h5a);
        rdchk(`ADDR_PERIOD_REG, 8'h5a, "period rw");
        wr(`ADDR_TIMER2_COUNT, 8'h33);
        rdchk(`ADDR_TIMER2_COUNT, 8'h33, "count rw");
        @(posedge clk);
        #1;
        chk("rd_data idle", 8'h00, rd_data);
        wr(`ADDR_TIMER2_CONTROL, 8'hfb);
        rdchk(`ADDR_TIMER2_CONTROL, 8'h7b, "control bit7 zero");
        rdchk(`ADDR_TIMER2_COUNT, 8'h33, "count after control write");
        $display("test registers done");
        // every prescale code with period 2: three counts per match
        wr(`ADDR_PERIOD_REG, 8'h02);
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_TIMER2_CONTROL, 8'h04 | 8'(s));
            meas(12 * (s == 0 ? 1 : (s == 1 ? 4 : 16)));
        end
        $display("test prescale done");
        // enable off freezes the count, on resumes
        wr(`ADDR_PERIOD_REG, 8'hff);
        wr(`ADDR_TIMER2_CONTROL, 8'h00);
        rd(`ADDR_TIMER2_COUNT, v);
        repeat (100) @(posedge clk);
        rdchk(`ADDR_TIMER2_COUNT, v, "count stopped");
        wr(`ADDR_TIMER2_CONTROL, 8'h04);
        repeat (40) @(posedge clk);
        rd(`ADDR_TIMER2_COUNT, v2);
        chk("count resumed", 8'h01, {7'h00, v2 !== v});
        $display("test enable done");
        // scaler clearing by count and control writes, divide by 16
        wr(`ADDR_TIMER2_CONTROL, 8'h06);
        wr(`ADDR_TIMER2_COUNT, 8'h80);
        clr_test(`ADDR_TIMER2_COUNT, 8'h80, 8'h80);
        clr_test(`ADDR_TIMER2_CONTROL, 8'h06, 8'h81);
        $display("test scaler clear done");
        // every postscale ratio, period 3 at divide by 1
        wr(`ADDR_PERIOD_REG, 8'h03);
        for (int k = 0; k < 16; k++) begin
            wr(`ADDR_TIMER2_CONTROL, {1'b0, 4'(k), 3'b100});
            wr(`ADDR_PERIPHERAL_FLAG, 8'h00);
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (flag !== 1'b1 && n < 1000);
            if (n >= 1000) timeout("flag");
            rdchk(`ADDR_PERIPHERAL_FLAG, 8'h02, "flag reg bit1");
            wr(`ADDR_PERIPHERAL_FLAG, 8'h00);
            n = 0;
            m = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
                if (tbase.match === 1'b1) m++;
            end while (flag !== 1'b1 && n < 1000);
            if (n >= 1000) timeout("flag");
            chk("matches per flag", 8'(k + 1), 8'(m));
        end
        $display("test postscale done");
        // reset in mid-run restores defaults
        wr(`ADDR_PERIOD_REG, 8'h33);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(`ADDR_PERIOD_REG, 8'hff, "period second reset");
        rdchk(`ADDR_TIMER2_COUNT, 8'h00, "count second reset");
        rdchk(`ADDR_TIMER2_CONTROL, 8'h00, "control second reset");
        rdchk(`ADDR_PERIPHERAL_FLAG, 8'h00, "flag second reset");
        $display("test second reset done");
        final_report();
    end
endmodule : period_timer_tb
